// ==== src/burst_addr_gen.sv ====
`timescale 1ns/1ps
module burst_addr_gen import ddr2_col_pkg::*; (
  input wire logic [COL_W-1:0] i_start,
  input wire logic [2:0] i_beat,
  input wire logic i_bl8,
  input wire logic i_interleave,
  output logic [COL_W-1:0] o_col
);
  wire [1:0] low_seq = i_start[1:0] + i_beat[1:0];
  wire [1:0] low_int = i_start[1:0] ^ i_beat[1:0];
  // nibble-based: sequential bit 2 simply toggles like interleave
  wire bit2 = i_bl8 ? (i_start[2] ^ i_beat[2]) : i_start[2];
  wire [1:0] low = i_interleave ? low_int : low_seq;
  assign o_col = {i_start[COL_W-1:3], bit2, low};
endmodule

// ==== src/ddr2_col_controller.sv ====
`timescale 1ns/1ps
module ddr2_col_controller import ddr2_col_pkg::*; #(
  parameter int DQ_W = 8
) (
  ddr2_col_if.controller bus,
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic [COL_W-1:0] i_req_col,
  input wire logic [8*DQ_W-1:0] i_req_wdata,
  input wire logic [DQ_W-1:0] i_req_wmask,
  input wire logic [2:0] i_cas_latency,
  input wire logic [2:0] i_additive_latency,
  input wire logic i_bl8,
  output logic o_req_ready,
  output logic [8*DQ_W-1:0] o_rdata,
  output logic o_rdata_valid
);
  localparam int DM_W = DQ_W / 8;
  localparam int PH_W = $clog2(LINK_DIV);
  typedef enum logic {ST_IDLE, ST_BUSY} state_t;

  state_t state_reg;
  logic [PH_W-1:0] ph_reg;
  logic ck_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic wr_reg;
  logic ready_reg;
  cmd_t cmd_reg;
  logic [COL_W-1:0] col_reg;
  logic [8*DQ_W-1:0] wdata_reg;
  logic [DQ_W-1:0] wmask_reg;
  logic [2*DQ_W-1:0] dq_reg;
  logic [2*DM_W-1:0] dm_reg;
  logic dq_oe_reg;
  logic dqs_reg;
  logic dqs_oe_reg;
  logic [2*DQ_W-1:0] dq_s1_reg;
  logic [2*DQ_W-1:0] dq_s2_reg;
  logic [8*DQ_W-1:0] rdata_reg;
  logic rvalid_reg;

  wire [PH_W-1:0] ph_next =
    (ph_reg == PH_W'(LINK_DIV - 1)) ? '0 : ph_reg + 1'b1;
  wire ck_next = ph_next < PH_W'(LINK_HALF);
  // outputs move on the link's falling edge, mid-way between samples
  wire fall_tick = ph_reg == PH_W'(LINK_HALF - 1);
  wire samp_tick = ph_reg == PH_W'(LINK_HALF + 1);
  wire take = fall_tick && ready_reg && i_req_valid;

  wire [CNT_W-1:0] rd_lat =
    CNT_W'(i_cas_latency) + CNT_W'(i_additive_latency);
  wire [CNT_W-1:0] wr_lat = rd_lat - 5'h01;
  wire [CNT_W-1:0] pairs = i_bl8 ? CNT_W'(PAIRS_BL8) : CNT_W'(PAIRS_BL4);
  wire [CNT_W-1:0] slot = cnt_reg + 5'h01;
  wire [CNT_W-1:0] wj = slot - wr_lat - 5'h01;
  wire [CNT_W-1:0] rj = cnt_reg - rd_lat - 5'h01;
  wire in_wr = (slot > wr_lat) && (slot <= wr_lat + pairs);
  wire in_rd = (cnt_reg > rd_lat) && (cnt_reg <= rd_lat + pairs);
  wire done = slot == (wr_reg ? wr_lat : rd_lat) + pairs + 5'h01;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ph_reg <= '0;
      ck_reg <= 1'b1;
      dq_s1_reg <= '0;
      dq_s2_reg <= '0;
    end else begin
      ph_reg <= ph_next;
      ck_reg <= ck_next;
      dq_s1_reg <= bus.dq;
      dq_s2_reg <= dq_s1_reg;
    end
  end

  // one burst at a time keeps spacing above two clocks, no interrupts
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ST_IDLE;
      ready_reg <= 1'b1;
      cnt_reg <= '0;
      wr_reg <= 1'b0;
      cmd_reg <= CMD_NOP;
      col_reg <= '0;
      wdata_reg <= '0;
      wmask_reg <= '0;
      dq_reg <= '0;
      dm_reg <= '0;
      dq_oe_reg <= 1'b0;
      dqs_reg <= 1'b0;
      dqs_oe_reg <= 1'b0;
    end else if (take) begin
      state_reg <= ST_BUSY;
      ready_reg <= 1'b0;
      cnt_reg <= '0;
      wr_reg <= i_req_write;
      cmd_reg <= i_req_write ? CMD_WRITE : CMD_READ;
      col_reg <= i_req_col;
      wdata_reg <= i_req_wdata;
      wmask_reg <= i_req_wmask;
    end else if (fall_tick && state_reg == ST_BUSY) begin
      cnt_reg <= slot;
      cmd_reg <= CMD_NOP;
      if (done) begin
        state_reg <= ST_IDLE;
        ready_reg <= 1'b1;
        dq_oe_reg <= 1'b0;
        dqs_oe_reg <= 1'b0;
        dqs_reg <= 1'b0;
      end else if (wr_reg && slot == wr_lat) begin
        dqs_oe_reg <= 1'b1;
        dqs_reg <= 1'b0;
      end else if (wr_reg && in_wr) begin
        dq_reg <= wdata_reg[32'(wj)*2*DQ_W +: 2*DQ_W];
        dm_reg <= wmask_reg[32'(wj)*2*DM_W +: 2*DM_W];
        dq_oe_reg <= 1'b1;
        dqs_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rdata_reg <= '0;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= 1'b0;
      if (samp_tick && state_reg == ST_BUSY && !wr_reg && in_rd) begin
        rdata_reg[32'(rj)*2*DQ_W +: 2*DQ_W] <= dq_s2_reg;
        rvalid_reg <= cnt_reg == rd_lat + pairs;
      end
    end
  end

  assign bus.ck = ck_reg;
  assign bus.cmd = cmd_reg;
  assign bus.col = col_reg;
  assign bus.dm = dm_reg;
  assign bus.dq_ctl = dq_reg;
  assign bus.dq_ctl_oe = dq_oe_reg;
  assign bus.dqs_ctl = dqs_reg;
  assign bus.dqs_ctl_oe = dqs_oe_reg;
  assign o_req_ready = ready_reg;
  assign o_rdata = rdata_reg;
  assign o_rdata_valid = rvalid_reg;
endmodule

// ==== src/ddr2_col_device.sv ====
`timescale 1ns/1ps
// Contract
// - bursts stay inside aligned page segment
// - no interruption with four-beat bursts
// - eight-beat: only same-type interrupt, four-beat boundary
// - column commands at least two clocks apart
// - column commands posted for additive latency
// - read latency is additive plus CAS latency
// - early column commands need nonzero additive latency
// - write latency equals read latency minus one
// - seamless back-to-back same-type bursts
// - only four or eight beats, three-bit field
// - one bit picks sequential or interleaved
// - sequential wraps in groups of four
// - interleaved beat i is start XOR i
// - no burst terminate command exists
// - first read data exactly read latency later
// - strobe low one clock before read data
// - read beats aligned with device strobe edges
// - CAS from mode, additive from extended register
// - controller write preamble before write latency
// - data after burst end is ignored
// - controller waits write recovery before precharge
// - one byte mask per eight lines, data timing
// - redundant read strobe disables byte mask
module ddr2_col_device import ddr2_col_pkg::*; #(
  parameter int DQ_W = 8,
  parameter int DEPTH = PIPE_DEPTH
) (
  ddr2_col_if.device bus,
  input wire logic i_rst,
  input wire logic [2:0] i_burst_length_field,
  input wire logic i_interleave,
  input wire logic [2:0] i_cas_latency,
  input wire logic [2:0] i_additive_latency,
  input wire logic i_redundant_read_strobe,
  input wire logic [COL_W-1:0] i_peek_col,
  output logic [DQ_W-1:0] o_peek_data,
  output logic [LAT_W-1:0] o_read_latency
);
  localparam int DM_W = DQ_W / 8;
  localparam int CFG_W = 11 + COL_W;

  logic [CFG_W-1:0] cfg_s1_reg;
  logic [CFG_W-1:0] cfg_s2_reg;
  cmd_t pipe_cmd_reg [DEPTH];
  logic [COL_W-1:0] pipe_col_reg [DEPTH];
  logic [DQ_W-1:0] mem [PAGE_COLS];

  logic [COL_W-1:0] rd_col_reg;
  logic [1:0] rd_pair_reg;
  logic [2:0] rd_left_reg;
  logic [COL_W-1:0] wr_col_reg;
  logic [1:0] wr_pair_reg;
  logic [2:0] wr_left_reg;

  logic [2*DQ_W-1:0] dq_dev_reg;
  logic dq_dev_oe_reg;
  logic dqs_dev_reg;
  logic dqs_dev_oe_reg;
  logic [DQ_W-1:0] peek_data_reg;
  logic [LAT_W-1:0] read_latency_reg;

  logic [COL_W-1:0] rd_addr [2];
  logic [COL_W-1:0] wr_addr [2];

  // mode settings are quasi-static but come from another domain
  always_ff @(posedge bus.ck or posedge i_rst) begin
    if (i_rst) begin
      cfg_s1_reg <= '0;
      cfg_s2_reg <= '0;
    end else begin
      cfg_s1_reg <= {i_peek_col, i_redundant_read_strobe,
                     i_additive_latency, i_cas_latency,
                     i_interleave, i_burst_length_field};
      cfg_s2_reg <= cfg_s1_reg;
    end
  end

  wire [2:0] bl_field = cfg_s2_reg[2:0];
  wire interleave = cfg_s2_reg[3];
  wire [2:0] cas_latency = cfg_s2_reg[6:4];
  wire [2:0] additive_latency = cfg_s2_reg[9:7];
  wire redundant_read_strobe = cfg_s2_reg[10];
  wire [COL_W-1:0] peek_col = cfg_s2_reg[CFG_W-1:11];

  // any code other than eight beats runs as four
  wire bl8 = bl_field == BL_CODE_8;
  wire [2:0] pairs = bl8 ? 3'(PAIRS_BL8) : 3'(PAIRS_BL4);

  wire [LAT_W-1:0] read_latency =
    LAT_W'(cas_latency) + LAT_W'(additive_latency);
  wire [LAT_W-1:0] write_latency = read_latency - 4'h1;

  // read latency below two is not supported
  wire [LAT_W-1:0] rd_idx = read_latency - 4'h1;
  wire [LAT_W-1:0] pre_idx = write_latency - 4'h1;

  // posted command line: a command waits here for its latency
  always_ff @(posedge bus.ck or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        pipe_cmd_reg[i] <= CMD_NOP;
        pipe_col_reg[i] <= '0;
      end
    end else begin
      pipe_cmd_reg[0] <= bus.cmd;
      pipe_col_reg[0] <= bus.col;
      for (int i = 1; i < DEPTH; i++) begin
        pipe_cmd_reg[i] <= pipe_cmd_reg[i-1];
        pipe_col_reg[i] <= pipe_col_reg[i-1];
      end
    end
  end

  wire rd_load = pipe_cmd_reg[rd_idx] == CMD_READ;
  wire pre_rd = pipe_cmd_reg[pre_idx] == CMD_READ;
  wire rd_more = rd_left_reg != 3'h0;
  wire [COL_W-1:0] rd_start = rd_load ? pipe_col_reg[rd_idx] : rd_col_reg;
  wire [1:0] rd_pair = rd_load ? 2'h0 : rd_pair_reg;
  wire [2:0] rd_left_base = rd_load ? pairs : rd_left_reg;

  wire wr_load = pipe_cmd_reg[pre_idx] == CMD_WRITE;
  wire wr_sample = wr_left_reg != 3'h0;
  wire mask_on = !redundant_read_strobe;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_beat
      burst_addr_gen u_rd_addr (
        .i_start(rd_start),
        .i_beat({rd_pair, 1'(g)}),
        .i_bl8(bl8),
        .i_interleave(interleave),
        .o_col(rd_addr[g])
      );
      burst_addr_gen u_wr_addr (
        .i_start(wr_col_reg),
        .i_beat({wr_pair_reg, 1'(g)}),
        .i_bl8(bl8),
        .i_interleave(interleave),
        .o_col(wr_addr[g])
      );
    end
  endgenerate

  // a new read load overrides the rest of a running burst
  always_ff @(posedge bus.ck or posedge i_rst) begin
    if (i_rst) begin
      rd_col_reg <= '0;
      rd_pair_reg <= 2'h0;
      rd_left_reg <= 3'h0;
      dq_dev_reg <= '0;
      dq_dev_oe_reg <= 1'b0;
      dqs_dev_reg <= 1'b0;
      dqs_dev_oe_reg <= 1'b0;
    end else if (rd_load || rd_more) begin
      rd_col_reg <= rd_start;
      rd_pair_reg <= rd_pair + 2'h1;
      rd_left_reg <= rd_left_base - 3'h1;
      dq_dev_reg <= {mem[rd_addr[1]], mem[rd_addr[0]]};
      dq_dev_oe_reg <= 1'b1;
      dqs_dev_reg <= 1'b1;
      dqs_dev_oe_reg <= 1'b1;
    end else if (pre_rd) begin
      dq_dev_oe_reg <= 1'b0;
      dqs_dev_reg <= 1'b0;
      dqs_dev_oe_reg <= 1'b1;
    end else begin
      dq_dev_oe_reg <= 1'b0;
      dqs_dev_reg <= 1'b0;
      dqs_dev_oe_reg <= 1'b0;
    end
  end

  // an old burst still samples on the edge a new write loads
  always_ff @(posedge bus.ck or posedge i_rst) begin
    if (i_rst) begin
      wr_col_reg <= '0;
      wr_pair_reg <= 2'h0;
      wr_left_reg <= 3'h0;
    end else if (wr_load) begin
      wr_col_reg <= pipe_col_reg[pre_idx];
      wr_pair_reg <= 2'h0;
      wr_left_reg <= pairs;
    end else if (wr_sample) begin
      wr_pair_reg <= wr_pair_reg + 2'h1;
      wr_left_reg <= wr_left_reg - 3'h1;
    end
  end

  // array has no reset: contents are undefined until written
  always_ff @(posedge bus.ck) begin
    for (int b = 0; b < 2; b++) begin
      for (int k = 0; k < DM_W; k++) begin
        if (wr_sample && !(mask_on && bus.dm[b*DM_W+k])) begin
          mem[wr_addr[b]][k*8 +: 8] <= bus.dq[b*DQ_W+k*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge bus.ck or posedge i_rst) begin
    if (i_rst) begin
      peek_data_reg <= '0;
      read_latency_reg <= '0;
    end else begin
      peek_data_reg <= mem[peek_col];
      read_latency_reg <= read_latency;
    end
  end

  assign bus.dq_dev = dq_dev_reg;
  assign bus.dq_dev_oe = dq_dev_oe_reg;
  assign bus.dqs_dev = dqs_dev_reg;
  assign bus.dqs_dev_oe = dqs_dev_oe_reg;
  assign o_peek_data = peek_data_reg;
  assign o_read_latency = read_latency_reg;
endmodule

// ==== src/ddr2_col_if.sv ====
`timescale 1ns/1ps
interface ddr2_col_if import ddr2_col_pkg::*; #(
  parameter int DQ_W = 8
);
  localparam int DM_W = DQ_W / 8;
  logic ck;
  cmd_t cmd;
  logic [COL_W-1:0] col;
  logic [2*DM_W-1:0] dm;
  logic [2*DQ_W-1:0] dq_ctl;
  logic dq_ctl_oe;
  logic [2*DQ_W-1:0] dq_dev;
  logic dq_dev_oe;
  logic dqs_ctl;
  logic dqs_ctl_oe;
  logic dqs_dev;
  logic dqs_dev_oe;
  logic [2*DQ_W-1:0] dq;
  logic dqs;
  // undriven bus reads as zero
  assign dq = dq_dev_oe ? dq_dev : (dq_ctl_oe ? dq_ctl : '0);
  assign dqs = dqs_dev_oe ? dqs_dev : (dqs_ctl_oe & dqs_ctl);
  modport device (
    input ck, cmd, col, dm, dq, dqs,
    output dq_dev, dq_dev_oe, dqs_dev, dqs_dev_oe
  );
  modport controller (
    input dq, dqs,
    output ck, cmd, col, dm, dq_ctl, dq_ctl_oe, dqs_ctl, dqs_ctl_oe
  );
endinterface

// ==== src/ddr2_col_pkg.sv ====
package ddr2_col_pkg;
  localparam int PAGE_COLS = 1024;
  localparam int COL_W = $clog2(PAGE_COLS);
  localparam int LAT_W = 4;
  localparam int PIPE_DEPTH = 16;
  localparam int COL_GAP_CYCLES = 2;
  localparam int PAIRS_BL4 = 2;
  localparam int PAIRS_BL8 = 4;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam int CLK_PERIOD_NS = 20;
  localparam int LINK_PERIOD_NS = 160;
  localparam int LINK_DIV = LINK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int LINK_HALF = LINK_DIV / 2;
  localparam int CNT_W = 5;
  typedef enum logic [1:0] {CMD_NOP, CMD_READ, CMD_WRITE} cmd_t;
endpackage

// ==== testbench/ddr2_col_properties.sv ====
`timescale 1ns/1ps
module ddr2_col_properties import ddr2_col_pkg::*; #(
  parameter int RD_LAT = 5
) (
  input wire logic ck,
  input wire logic i_rst,
  input wire logic i_bl8,
  input wire cmd_t cmd,
  input wire logic dq_ctl_oe,
  input wire logic dqs_ctl,
  input wire logic dqs_ctl_oe,
  input wire logic dq_dev_oe,
  input wire logic dqs_dev,
  input wire logic dqs_dev_oe
);
  localparam int WR_LAT = RD_LAT - 1;
  localparam int RD1 = RD_LAT + 1;
  localparam int WD1 = WR_LAT + 1;
  default clocking cb @(posedge ck); endclocking
  default disable iff (i_rst);
  chk_read_first_pair: assert property (
    cmd == CMD_READ |-> ##RD_LAT (dqs_dev_oe && !dqs_dev && !dq_dev_oe)
    ##1 (dq_dev_oe && dqs_dev))
    else $error("read preamble or first pair misplaced");
  chk_read_preamble: assert property (
    $rose(dqs_dev_oe) |-> !dqs_dev ##1 (dqs_dev && dq_dev_oe))
    else $error("read strobe not low one cycle before data");
  chk_read_strobe_align: assert property (
    dq_dev_oe |-> dqs_dev_oe && dqs_dev)
    else $error("read data without device strobe");
  chk_write_latency: assert property (
    cmd == CMD_WRITE |-> ##WR_LAT (dqs_ctl_oe && !dqs_ctl && !dq_ctl_oe)
    ##1 (dq_ctl_oe && dqs_ctl))
    else $error("write preamble or first pair misplaced");
  chk_write_strobe: assert property (
    dq_ctl_oe |-> dqs_ctl_oe && dqs_ctl)
    else $error("write data without controller strobe");
  chk_cmd_spacing: assert property (
    cmd != CMD_NOP |=> cmd == CMD_NOP)
    else $error("column commands closer than two cycles");
  chk_write_len_four: assert property (
    cmd == CMD_WRITE && !i_bl8 |-> ##WD1 dq_ctl_oe [*2] ##1 !dq_ctl_oe)
    else $error("four-beat write pair count wrong");
  chk_write_len_eight: assert property (
    cmd == CMD_WRITE && i_bl8 |-> ##WD1 dq_ctl_oe [*4] ##1 !dq_ctl_oe)
    else $error("eight-beat write pair count wrong");
  chk_read_len_four: assert property (
    cmd == CMD_READ && !i_bl8 |-> ##RD1 dq_dev_oe [*2] ##1 !dq_dev_oe)
    else $error("four-beat read pair count wrong");
  chk_read_len_eight: assert property (
    cmd == CMD_READ && i_bl8 |-> ##RD1 dq_dev_oe [*4] ##1 !dq_dev_oe)
    else $error("eight-beat read pair count wrong");
  chk_no_stop_cmd: assert property (
    cmd inside {CMD_NOP, CMD_READ, CMD_WRITE})
    else $error("unknown column command on link");
  cover property (cmd == CMD_READ && i_bl8);
  cover property (cmd == CMD_WRITE && !i_bl8);
  cover property ($rose(dq_dev_oe));
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
module tb import ddr2_col_pkg::*;;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [COL_W-1:0] req_col = '0;
  logic [COL_W-1:0] peek_col = '0;
  logic [63:0] req_wdata = '0;
  logic [7:0] req_wmask = '0;
  logic bl8 = 1'b0;
  logic il = 1'b0;
  logic rrs = 1'b0;
  localparam logic [2:0] CAS_LAT_SET = 3'h3;
  // nonzero so commands before the row delay stay legal
  localparam logic [2:0] ADD_LAT_SET = 3'h2;
  logic [2:0] cas_lat = CAS_LAT_SET;
  logic [2:0] add_lat = ADD_LAT_SET;
  logic [2:0] len_code = 3'h2;
  logic [63:0] got = '0;
  wire logic req_ready;
  wire logic rdata_valid;
  wire logic [63:0] rdata;
  wire logic [7:0] peek_data;
  wire logic [LAT_W-1:0] read_latency;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  ddr2_col_if #(.DQ_W(8)) bus_if ();
  ddr2_col_controller #(.DQ_W(8)) i_ddr2_col_controller (
    .bus(bus_if), .i_clock(i_clock), .i_rst(i_rst),
    .i_req_valid(req_valid), .i_req_write(req_write), .i_req_col(req_col),
    .i_req_wdata(req_wdata), .i_req_wmask(req_wmask),
    .i_cas_latency(cas_lat), .i_additive_latency(add_lat), .i_bl8(bl8),
    .o_req_ready(req_ready), .o_rdata(rdata), .o_rdata_valid(rdata_valid));
  ddr2_col_device #(.DQ_W(8), .DEPTH(PIPE_DEPTH)) i_ddr2_col_device (
    .bus(bus_if), .i_rst(i_rst),
    .i_burst_length_field(len_code), .i_interleave(il),
    .i_cas_latency(cas_lat), .i_additive_latency(add_lat),
    .i_redundant_read_strobe(rrs), .i_peek_col(peek_col),
    .o_peek_data(peek_data), .o_read_latency(read_latency));
  ddr2_col_properties #(
    .RD_LAT(int'(CAS_LAT_SET) + int'(ADD_LAT_SET))
  ) i_ddr2_col_properties (
    .ck(bus_if.ck), .i_rst(i_rst), .i_bl8(bl8), .cmd(bus_if.cmd),
    .dq_ctl_oe(bus_if.dq_ctl_oe), .dqs_ctl(bus_if.dqs_ctl),
    .dqs_ctl_oe(bus_if.dqs_ctl_oe), .dq_dev_oe(bus_if.dq_dev_oe),
    .dqs_dev(bus_if.dqs_dev), .dqs_dev_oe(bus_if.dqs_dev_oe));
  always #(CLK_PERIOD_NS / 2) i_clock = ~i_clock;
  task automatic print_verdict();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // run is about 2700 cycles, so this leaves wide margin
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 30000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic check(input string name, input logic [63:0] seen,
      input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // request is held until ready falls, read data latched on its pulse
  task automatic xfer(input logic wr, input logic [COL_W-1:0] c,
      input logic [63:0] d, input logic [7:0] m);
    int n;
    @(negedge i_clock);
    req_write = wr;
    req_col = c;
    req_wdata = d;
    req_wmask = m;
    req_valid = 1'b1;
    n = 0;
    while (req_ready !== 1'b0 && n < 100) begin
      @(posedge i_clock);
      #1;
      n++;
    end
    check("req_taken", {63'h0, req_ready}, 64'h0);
    @(negedge i_clock);
    req_valid = 1'b0;
    n = 0;
    while (req_ready !== 1'b1 && n < 300) begin
      @(posedge i_clock);
      #1;
      if (rdata_valid === 1'b1) got = rdata;
      n++;
    end
    check("req_done", {63'h0, req_ready}, 64'h1);
  endtask
  // config passes two link flops, so wait several link cycles
  task automatic set_cfg(input logic b8, input logic ilv, input logic r);
    @(negedge i_clock);
    bl8 = b8;
    len_code = b8 ? BL_CODE_8 : 3'h2;
    il = ilv;
    rrs = r;
    repeat (5 * LINK_DIV) @(negedge i_clock);
  endtask
  task automatic peek(input logic [COL_W-1:0] c, input logic [7:0] e);
    @(negedge i_clock);
    peek_col = c;
    repeat (6 * LINK_DIV) @(negedge i_clock);
    check("peek", {56'h0, peek_data}, {56'h0, e});
  endtask
  function automatic logic [COL_W-1:0] exp_col(input logic [COL_W-1:0] s,
      input logic [2:0] b);
    logic [2:0] low;
    low = il ? (s[2:0] ^ b) : {s[2] ^ b[2], s[1:0] + b[1:0]};
    return {s[COL_W-1:3], low};
  endfunction
  task automatic t_burst(input logic b8, input logic ilv,
      input logic [COL_W-1:0] s);
    logic [63:0] d;
    int nb;
    nb = b8 ? 8 : 4;
    for (int b = 0; b < 8; b++) d[b*8 +: 8] = {s[3:0], 4'(b)};
    set_cfg(b8, ilv, 1'b0);
    xfer(1'b1, s, d, 8'h00);
    got = '0;
    xfer(1'b0, s, 64'h0, 8'h00);
    check("rdata", b8 ? got : {32'h0, got[31:0]},
      b8 ? d : {32'h0, d[31:0]});
    for (int b = 0; b < nb; b++) begin
      peek(exp_col(s, 3'(b)), d[b*8 +: 8]);
    end
  endtask
  task automatic t_mask(input logic r);
    set_cfg(1'b0, 1'b0, r);
    xfer(1'b1, 10'h100, 64'h0000_0000_1111_1111, 8'h00);
    xfer(1'b1, 10'h100, 64'h0000_0000_2222_2222, 8'h05);
    for (int b = 0; b < 4; b++) begin
      peek(10'h100 + 10'(b),
        (!r && b % 2 == 0) ? 8'h11 : 8'h22);
    end
  endtask
  initial begin
    repeat (6) @(negedge i_clock);
    i_rst = 1'b0;
    repeat (4 * LINK_DIV) @(negedge i_clock);
    check("read_latency", {60'h0, read_latency},
      {60'h0, LAT_W'(cas_lat) + LAT_W'(add_lat)});
    t_burst(1'b0, 1'b0, 10'h005);
    t_burst(1'b0, 1'b1, 10'h00b);
    t_burst(1'b1, 1'b0, 10'h2f5);
    t_burst(1'b1, 1'b1, 10'h3fe);
    t_mask(1'b0);
    t_mask(1'b1);
    print_verdict();
  end
endmodule
